// File: hdl/capture_pkg.sv
/*
 * Constants shared by the input capture channel: register offsets, control
 * field positions, reset values, mode codes and prescaler counts.
 * Assumes a 32-bit AHB-Lite register window decoded on the low address bits.
 */
package capture_pkg;
    // Register byte offsets within the channel window
    localparam logic [4:0] CTRL_OFF = 5'h00;
    localparam logic [4:0] CTRL_CLR_OFF = 5'h04;
    localparam logic [4:0] CTRL_SET_OFF = 5'h08;
    localparam logic [4:0] CTRL_INV_OFF = 5'h0c;
    localparam logic [4:0] BUF_OFF = 5'h10;

    // Control field positions
    localparam int ON_BIT = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int FIRST_EDGE_BIT = 9;
    localparam int WIDE_BIT = 8;
    localparam int TBASE_BIT = 7;
    localparam int RATE_LSB = 5;
    localparam int OVF_BIT = 4;
    localparam int BNE_BIT = 3;
    localparam int MODE_LSB = 0;

    // Writable control bits; the rest read as zero apart from the overflow and not-empty flags
    localparam logic [15:0] CTRL_WMASK = 16'ha3e7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Capture mode codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_RISE = 3'h3;
    localparam logic [2:0] MODE_RISE4 = 3'h4;
    localparam logic [2:0] MODE_RISE16 = 3'h5;
    localparam logic [2:0] MODE_FIRST_EDGE = 3'h6;
    localparam logic [2:0] MODE_IRQ_ONLY = 3'h7;

    // Last prescaler count before a capture
    localparam logic [3:0] PRESC4_LAST = 4'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hf;

    // Buffer geometry
    localparam int FIFO_DEPTH = 4;
    localparam int DATA_W = 32;
endpackage : capture_pkg

// File: hdl/pin_edge_detect.sv
/*
 * Pin synchroniser and edge detector for the capture input.
 * Assumes an asynchronous pin; reports an edge once two synchronised
 * samples agree on a new level.
 */
`timescale 1ns/1ns
module pin_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Pin and edge pulses
    input wire logic pinIn,
    output logic rise,
    output logic fall
);
    logic [2:0] syncPipe_r;
    logic level_r;
    logic level_nxt;
    logic agree;

    // Only the second and third stages are compared
    assign agree = (syncPipe_r[1] == syncPipe_r[2]);

    always_comb begin
        level_nxt = agree ? syncPipe_r[2] : level_r;
        rise = agree && syncPipe_r[2] && !level_r;
        fall = agree && !syncPipe_r[2] && level_r;
    end

    // Three-stage pipe plus accepted level
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            syncPipe_r <= 3'h0;
            level_r <= 1'b0;
        end else begin
            syncPipe_r <= {syncPipe_r[1:0], pinIn};
            level_r <= level_nxt;
        end
    end
endmodule : pin_edge_detect

// File: hdl/capture_fifo.sv
/*
 * Small flip-flop FIFO holding captured time base values.
 * A push while full is dropped without a write; flush empties it at once.
 */
`timescale 1ns/1ns
module capture_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    input wire logic flush,
    // Write side
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    output logic full,
    // Read side
    input wire logic pop,
    output logic [WIDTH-1:0] popData,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [PW:0] count_r, count_nxt;
    logic doPush, doPop;

    assign full = (count_r == (PW+1)'(DEPTH));
    assign empty = (count_r == '0);
    assign popData = mem_r[rdPtr_r];
    assign doPush = push && !full;
    assign doPop = pop && !empty;

    // Pointer arithmetic wraps on a power-of-two depth
    always_comb begin
        wrPtr_nxt = wrPtr_r + PW'(doPush);
        rdPtr_nxt = rdPtr_r + PW'(doPop);
        count_nxt = count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
        if (flush) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            count_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage needs no reset; empty guards stale entries
    always_ff @(posedge clk) begin
        if (doPush && !flush) begin
            mem_r[wrPtr_r] <= pushData;
        end
    end
endmodule : capture_fifo

// File: hdl/input_capture_channel.sv
/*
 * One input capture channel with an AHB-Lite register slave.
 * Assumes time bases and power-mode levels come from the mclk domain and
 * the capture pin is asynchronous.
 */
// Implementation choices: the address map and register access over AHB-Lite.
// How it works
// - Clearing enable resets buffer, flags and counters and blocks interrupts.
// - Idle-stop set halts the channel while the device idles.
// - First-edge bit, used only in mode 110, picks rising or falling first.
// - Wide-capture bit set captures the 32-bit cascaded timer value.
// - In 16-bit capture, select 0 takes second base, 1 takes first.
// - Interrupt rate field gives one to four captures per interrupt.
// - Read-only overflow flag shows that a capture overflow happened.
// - Read-only not-empty flag shows unread captured values remain.
// - Mode 000 disables capturing.
// - Mode 001 responds to every rising and falling edge.
// - Mode 010 captures falling edges, mode 011 rising edges.
// - Mode 100 captures every fourth rise, mode 101 every sixteenth.
// - Mode 110 waits for the chosen first edge, then every edge.
// - Mode 111 raises interrupts on edges only during sleep or idle.
// - Unimplemented control bits ignore writes and read zero.
// - Each capture event latches the selected time base value.
// - Captures queue in a four-entry FIFO read through the buffer register.
// - Pin edges during sleep or idle request a device wake-up.
`timescale 1ns/1ns
module input_capture_channel #(
    parameter int DEPTH = capture_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Capture pin and time bases
    input wire logic captureInputPin,
    input wire logic [15:0] firstTimeBase,
    input wire logic [15:0] secondTimeBase,
    // Power modes and system requests
    input wire logic idleMode,
    input wire logic sleepMode,
    output logic captureIrq,
    output logic wakeReq
);
    localparam int W = capture_pkg::DATA_W;

    logic [1:0] rstPipe_r;
    logic rstN;
    logic rise, fall, anyEdge;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic ovf_r, ovf_nxt;
    logic armed_r, armed_nxt;
    logic [3:0] presc_r, presc_nxt;
    logic [1:0] evCnt_r, evCnt_nxt;
    logic irq_r, irq_nxt, wake_r, wake_nxt;
    logic wrPend_r, wrPend_nxt;
    logic [4:0] wrAddr_r, wrAddr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic onBit, idleStop, firstEdge, wide, tbSel;
    logic [1:0] rate;
    logic [2:0] mode;
    logic lowPower, halted, capEv, irqEv, busSel, busRd, pop;
    logic fifoFull, fifoEmpty;
    logic [W-1:0] capValue, popData;

    // Reset released through two flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstN = rstPipe_r[1];

    pin_edge_detect pin_edge_detect_inst (
        .clk(mclk),
        .rstN(rstN),
        .pinIn(captureInputPin),
        .rise(rise),
        .fall(fall)
    );

    // Control field decode
    assign onBit = ctrl_r[capture_pkg::ON_BIT];
    assign idleStop = ctrl_r[capture_pkg::IDLE_STOP_BIT];
    assign firstEdge = ctrl_r[capture_pkg::FIRST_EDGE_BIT];
    assign wide = ctrl_r[capture_pkg::WIDE_BIT];
    assign tbSel = ctrl_r[capture_pkg::TBASE_BIT];
    assign rate = ctrl_r[capture_pkg::RATE_LSB +: 2];
    assign mode = ctrl_r[capture_pkg::MODE_LSB +: 3];
    assign anyEdge = rise || fall;
    assign lowPower = idleMode || sleepMode;
    // Sleep stops the bus clock in a real chip; modelled as a halt
    assign halted = sleepMode || (idleMode && idleStop);

    // Time base selection for the captured entry
    always_comb begin
        if (wide) begin
            capValue = {secondTimeBase, firstTimeBase};
        end else if (tbSel) begin
            capValue = {16'h0000, firstTimeBase};
        end else begin
            capValue = {16'h0000, secondTimeBase};
        end
    end

    // Capture event qualification per mode
    always_comb begin
        capEv = 1'b0;
        armed_nxt = armed_r;
        presc_nxt = presc_r;
        if (onBit && !halted) begin
            unique case (mode)
                capture_pkg::MODE_OFF: capEv = 1'b0;
                capture_pkg::MODE_EVERY_EDGE: capEv = anyEdge;
                capture_pkg::MODE_FALL: capEv = fall;
                capture_pkg::MODE_RISE: capEv = rise;
                capture_pkg::MODE_RISE4, capture_pkg::MODE_RISE16: begin
                    if (rise) begin
                        capEv = (presc_r == ((mode == capture_pkg::MODE_RISE4) ?
                            capture_pkg::PRESC4_LAST : capture_pkg::PRESC16_LAST));
                        presc_nxt = capEv ? 4'h0 : presc_r + 4'h1;
                    end
                end
                capture_pkg::MODE_FIRST_EDGE: begin
                    if (armed_r) begin
                        capEv = anyEdge;
                    end else begin
                        capEv = firstEdge ? rise : fall;
                        armed_nxt = capEv;
                    end
                end
                capture_pkg::MODE_IRQ_ONLY: capEv = 1'b0;
            endcase
        end
        // Counters restart whenever the channel or mode is off
        if (!onBit || mode == capture_pkg::MODE_OFF) begin
            armed_nxt = 1'b0;
            presc_nxt = 4'h0;
        end
    end

    // Interrupt pacing, overflow and wake requests
    always_comb begin
        evCnt_nxt = evCnt_r;
        irqEv = 1'b0;
        ovf_nxt = ovf_r;
        if (capEv) begin
            if (evCnt_r == rate) begin
                irqEv = 1'b1;
                evCnt_nxt = 2'h0;
            end else begin
                evCnt_nxt = evCnt_r + 2'h1;
            end
            if (fifoFull) begin
                ovf_nxt = 1'b1;
            end
        end
        if (onBit && mode == capture_pkg::MODE_IRQ_ONLY && lowPower && anyEdge) begin
            irqEv = 1'b1;
        end
        irq_nxt = irqEv && onBit;
        wake_nxt = onBit && mode != capture_pkg::MODE_OFF && lowPower && anyEdge;
        if (!onBit) begin
            evCnt_nxt = 2'h0;
            ovf_nxt = 1'b0;
        end
    end

    capture_fifo #(
        .WIDTH(W),
        .DEPTH(DEPTH)
    ) capture_fifo_inst (
        .clk(mclk),
        .rstN(rstN),
        .flush(!onBit),
        .push(capEv),
        .pushData(capValue),
        .full(fifoFull),
        .pop(pop),
        .popData(popData),
        .empty(fifoEmpty)
    );

    // AHB-Lite address phase decode; always zero wait state, OKAY
    // Buffer reads pop in the address phase, so the entry stands one cycle later
    assign busSel = hsel && htrans[1] && hready;
    assign busRd = busSel && !hwrite;
    assign pop = busRd && haddr[4:0] == capture_pkg::BUF_OFF;

    always_comb begin
        wrPend_nxt = busSel && hwrite;
        wrAddr_nxt = haddr[4:0];
        rdata_nxt = 32'h0000_0000;
        if (busRd) begin
            unique case (haddr[4:0])
                capture_pkg::CTRL_OFF, capture_pkg::CTRL_CLR_OFF,
                capture_pkg::CTRL_SET_OFF, capture_pkg::CTRL_INV_OFF: begin
                    rdata_nxt[15:0] = ctrl_r;
                    rdata_nxt[capture_pkg::OVF_BIT] = ovf_r;
                    rdata_nxt[capture_pkg::BNE_BIT] = !fifoEmpty;
                end
                capture_pkg::BUF_OFF: rdata_nxt = popData;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // Data-phase write; clear, set and invert aliases act on control
        ctrl_nxt = ctrl_r;
        if (wrPend_r) begin
            unique case (wrAddr_r)
                capture_pkg::CTRL_OFF: ctrl_nxt = hwdata[15:0];
                capture_pkg::CTRL_CLR_OFF: ctrl_nxt = ctrl_r & ~hwdata[15:0];
                capture_pkg::CTRL_SET_OFF: ctrl_nxt = ctrl_r | hwdata[15:0];
                capture_pkg::CTRL_INV_OFF: ctrl_nxt = ctrl_r ^ hwdata[15:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        ctrl_nxt = ctrl_nxt & capture_pkg::CTRL_WMASK;
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ctrl_r <= capture_pkg::CTRL_RESET;
            ovf_r <= 1'b0;
            armed_r <= 1'b0;
            presc_r <= 4'h0;
            evCnt_r <= 2'h0;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            wrPend_r <= 1'b0;
            wrAddr_r <= 5'h00;
            rdata_r <= 32'h0000_0000;
            hreadyout <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ovf_r <= ovf_nxt;
            armed_r <= armed_nxt;
            presc_r <= presc_nxt;
            evCnt_r <= evCnt_nxt;
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
            wrPend_r <= wrPend_nxt;
            wrAddr_r <= wrAddr_nxt;
            rdata_r <= rdata_nxt;
            hreadyout <= 1'b1;
        end
    end

    // Response is always OKAY
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    assign hrdata = rdata_r;
    assign captureIrq = irq_r;
    assign wakeReq = wake_r;

    // Checks
    chk_off_flush: assert property (@(posedge mclk) disable iff (!rstN)
        !onBit |=> fifoEmpty && !ovf_r && !captureIrq)
        else $error("disabled channel kept state");
    chk_mode_off: assert property (@(posedge mclk) disable iff (!rstN)
        mode == capture_pkg::MODE_OFF |-> !capEv)
        else $error("capture in off mode");
    chk_edge_pol: assert property (@(posedge mclk) disable iff (!rstN)
        capEv && mode == capture_pkg::MODE_RISE |-> rise && !fall)
        else $error("rising mode took a non-rising edge");
    chk_presc_four: assert property (@(posedge mclk) disable iff (!rstN)
        capEv && mode == capture_pkg::MODE_RISE4 |-> $past(presc_r) == 4'h2 || presc_r == 4'h3)
        else $error("prescale by four wrong");
    chk_halt_idle: assert property (@(posedge mclk) disable iff (!rstN)
        idleMode && idleStop |-> !capEv)
        else $error("capture while halted in idle");
    chk_wide_value: assert property (@(posedge mclk) disable iff (!rstN)
        capEv && wide |-> capValue[31:16] == secondTimeBase)
        else $error("wide capture lost upper half");
    chk_ovf_set: assert property (@(posedge mclk) disable iff (!rstN)
        capEv && fifoFull && onBit |=> ovf_r)
        else $error("overflow not flagged");
    chk_irq_rate: assert property (@(posedge mclk) disable iff (!rstN)
        capEv && evCnt_r != rate && mode != capture_pkg::MODE_IRQ_ONLY |=> !captureIrq)
        else $error("interrupt before rate reached");
    chk_reserved: assert property (@(posedge mclk) disable iff (!rstN)
        ##1 (ctrl_r & ~capture_pkg::CTRL_WMASK) == 16'h0000)
        else $error("unimplemented control bit set");
    chk_bne_read: assert property (@(posedge mclk) disable iff (!rstN)
        busRd && haddr[4:0] == capture_pkg::CTRL_OFF |=> hrdata[3] == !$past(fifoEmpty))
        else $error("not-empty flag misreported");

    cov_first_edge: cover property (@(posedge mclk) disable iff (!rstN)
        capEv && mode == capture_pkg::MODE_FIRST_EDGE ##[1:50] capEv);
    cov_overflow: cover property (@(posedge mclk) disable iff (!rstN) capEv && fifoFull);
    cov_rate_four: cover property (@(posedge mclk) disable iff (!rstN) irqEv && rate == 2'h3);
    cov_wake: cover property (@(posedge mclk) disable iff (!rstN) wakeReq);
endmodule : input_capture_channel

// File: bench/capture_pin_driver.sv
/*
 * Partner model: the external signal that drives the capture input pin.
 * Assumes mclk comes from the bench; the pin changes just after a rising edge.
 */
`timescale 1ns/1ns
module capture_pin_driver (
    // Clock
    input wire logic mclk,
    // Capture pin
    output logic pinLevel
);
    // Pin rests low until a scenario moves it
    initial pinLevel = 1'b0;

    // Each level is held for hold cycles; fewer than two may slip past the synchroniser
    task automatic toggle(input int n, input int hold);
        repeat (n) begin
            @(posedge mclk);
            pinLevel <= ~pinLevel;
            repeat (hold - 1) @(posedge mclk);
        end
        repeat (8) @(posedge mclk); // Synchroniser and capture path need a few cycles
    endtask : toggle
endmodule : capture_pin_driver

// File: bench/input_capture_channel_tb.sv
/*
 * Self-checking bench for the input capture channel.
 * Assumes the channel answers AHB-Lite without wait states but waits anyway.
 */
`timescale 1ns/1ns
module input_capture_channel_tb;
    localparam logic [31:0] CTRL = {27'h0, capture_pkg::CTRL_OFF};
    localparam logic [31:0] BUF = {27'h0, capture_pkg::BUF_OFF};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin;
    logic [15:0] firstTimeBase = 16'h1234;
    logic [15:0] secondTimeBase = 16'hbeef;
    logic idleMode = 1'b0;
    logic sleepMode = 1'b0;
    logic captureIrq;
    logic wakeReq;
    int failures = 0;
    int checksDone = 0;
    int irqCount = 0;
    int wakeCount = 0;

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // Pulse counters; one-cycle pulses are seen at every edge
    always @(posedge mclk) begin
        if (captureIrq === 1'b1) irqCount++;
        if (wakeReq === 1'b1) wakeCount++;
    end

    input_capture_channel input_capture_channel_inst (
        .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .captureInputPin(pin), .firstTimeBase(firstTimeBase),
        .secondTimeBase(secondTimeBase), .idleMode(idleMode), .sleepMode(sleepMode),
        .captureIrq(captureIrq), .wakeReq(wakeReq)
    );

    capture_pin_driver capture_pin_driver_inst (.mclk(mclk), .pinLevel(pin));

    task automatic stopTest;
        $display("Checks %0d, failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stopTest

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One single transfer; the wait for hready is bounded
    task automatic busCycle(input logic [31:0] a, input logic w, input logic [31:0] wd,
                            output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge mclk); // Idle edge before each transfer, also after disable
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rdat = hrdata;
        check("response", 32'h0, {31'h0, hresp});
        if (n >= 100) begin
            failures++;
            stopTest();
        end
    endtask : busCycle

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        busCycle(a, 1'b1, d, x);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        busCycle(a, 1'b0, 32'h0, d);
    endtask : rd

    // f holds idle stop, first edge, wide, time base select from high to low
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] r,
                                        input logic [3:0] f);
        return {16'h0, 1'b1, 1'b0, f[3], 3'h0, f[2], f[1], f[0], r, 2'h0, m};
    endfunction : ctl

    // Drains n entries of value v, watching the not-empty flag on the way
    task automatic expectEntries(input int n, input logic [31:0] v);
        logic [31:0] d;
        for (int i = 0; i < n; i++) begin
            rd(CTRL, d);
            check("not empty flag", 32'h1, {31'h0, d[3]});
            rd(BUF, d);
            check("buffer entry", v, d);
        end
        rd(CTRL, d);
        check("not empty flag", 32'h0, {31'h0, d[3]});
    endtask : expectEntries

    task automatic runCase(input logic [2:0] m, input logic [3:0] f, input int t, input int n,
                           input logic [31:0] v);
        wr(CTRL, 32'h0);
        wr(CTRL, ctl(m, 2'h0, f));
        capture_pin_driver_inst.toggle(t, 3);
        expectEntries(n, v);
    endtask : runCase

    task automatic regScenario;
        logic [31:0] d;
        rd(CTRL, d);
        check("control reset", 32'h0, d);
        wr(CTRL, 32'hffffffff);
        rd(CTRL, d);
        check("control writable", 32'h0000a3e7, d);
        wr(32'h4, 32'hffff8000);
        rd(CTRL, d);
        check("clear alias", 32'h000023e7, d);
        wr(32'h8, 32'h00008000);
        wr(32'hc, 32'h00000007);
        rd(32'hc, d);
        check("set invert alias", 32'h0000a3e0, d);
        rd(32'h14, d);
        check("unmapped read", 32'h0, d);
        wr(CTRL, 32'h0);
    endtask : regScenario

    // Prescaled modes: one rise short gives nothing, the last rise captures
    task automatic prescScenario(input logic [2:0] m, input int rises);
        wr(CTRL, 32'h0);
        wr(CTRL, ctl(m, 2'h0, 4'h1));
        capture_pin_driver_inst.toggle(2 * rises - 2, 2);
        expectEntries(0, 32'h0);
        capture_pin_driver_inst.toggle(2, 2);
        expectEntries(1, {16'h0, firstTimeBase});
    endtask : prescScenario

    task automatic rateScenario;
        int base;
        for (int r = 0; r < 4; r++) begin
            wr(CTRL, 32'h0);
            wr(CTRL, ctl(3'h3, r[1:0], 4'h1));
            base = irqCount;
            capture_pin_driver_inst.toggle(8, 3);
            check("interrupts", 32'(4 / (r + 1)), 32'(irqCount - base));
        end
    endtask : rateScenario

    // Five captures into four places, then disable clears everything
    task automatic overflowScenario;
        logic [31:0] d;
        int base;
        wr(CTRL, 32'h0);
        wr(CTRL, ctl(3'h3, 2'h3, 4'h1));
        base = irqCount;
        capture_pin_driver_inst.toggle(10, 2);
        check("interrupts", 32'h1, 32'(irqCount - base));
        rd(CTRL, d);
        check("overflow flag", 32'h1, {31'h0, d[4]});
        expectEntries(4, {16'h0, firstTimeBase});
        wr(CTRL, 32'h0);
        rd(CTRL, d);
        check("control after disable", 32'h0, d);
        wr(CTRL, 32'h00000003);
        base = irqCount;
        capture_pin_driver_inst.toggle(2, 3);
        check("interrupts off", 32'h0, 32'(irqCount - base));
        expectEntries(0, 32'h0);
    endtask : overflowScenario

    task automatic powerScenario;
        int base;
        @(posedge mclk);
        idleMode <= 1'b1;
        runCase(3'h3, 4'h9, 2, 0, 32'h0);
        base = wakeCount;
        runCase(3'h3, 4'h1, 2, 1, {16'h0, firstTimeBase});
        check("wake requests", 32'h2, 32'(wakeCount - base));
        @(posedge mclk);
        idleMode <= 1'b0;
        sleepMode <= 1'b1;
        wr(CTRL, ctl(3'h7, 2'h0, 4'h0));
        base = irqCount;
        capture_pin_driver_inst.toggle(2, 3);
        check("sleep interrupt", 32'h2, 32'(irqCount - base));
        @(posedge mclk);
        sleepMode <= 1'b0;
        base = irqCount;
        capture_pin_driver_inst.toggle(2, 3);
        check("awake interrupt", 32'h0, 32'(irqCount - base));
    endtask : powerScenario

    // Main sequence
    initial begin
        int n;
        n = 0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        check("ready after reset", 32'h1, {31'h0, hreadyout});
        if (failures != 0) stopTest();
        regScenario();
        runCase(3'h3, 4'h1, 2, 1, {16'h0, firstTimeBase});
        runCase(3'h2, 4'h0, 2, 1, {16'h0, secondTimeBase});
        runCase(3'h3, 4'h3, 2, 1, {secondTimeBase, firstTimeBase});
        runCase(3'h3, 4'h2, 2, 1, {secondTimeBase, firstTimeBase});
        runCase(3'h1, 4'h0, 2, 2, {16'h0, secondTimeBase});
        runCase(3'h0, 4'h1, 2, 0, 32'h0);
        capture_pin_driver_inst.toggle(1, 2);
        runCase(3'h6, 4'h4, 3, 2, {16'h0, secondTimeBase});
        capture_pin_driver_inst.toggle(1, 2);
        runCase(3'h6, 4'h0, 3, 3, {16'h0, secondTimeBase});
        prescScenario(3'h4, 4);
        prescScenario(3'h5, 16);
        rateScenario();
        overflowScenario();
        powerScenario();
        stopTest();
    end
endmodule : input_capture_channel_tb
